/* File: verilog/bcdc_counter.sv */
`timescale 1ns/100ps
module bcdc_counter (
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic RESETN_I,
   // Counter controls
   input wire logic COUNT_CLOCK_I,
   input wire logic PRESET_LOAD_N_I,
   input wire logic COUNT_INHIBIT_I,
   input wire logic COUNT_DOWN_I,
   input wire logic [3:0] PRESET_VALUE_I,
   // Counter outputs
   output logic [3:0] COUNT_VALUE_O,
   output logic TERMINAL_COUNT_O,
   output logic RIPPLE_CLOCK_OUT_O
);

   // ==========================================
   // Input synchronisers
   // Every control pin is foreign to CLOCK_I, so all of them share
   // one two-stage chain and keep their relative timing through it
   logic [7:0] pins;
   logic [7:0] sync1_reg;
   logic [7:0] sync1_next;
   logic [7:0] sync2_reg;
   logic [7:0] sync2_next;
   logic clk_s;
   logic dir_s;
   logic load_n_s;
   logic inh_s;
   logic [3:0] pre_s;

   // Packed in the order of the package bit positions
   assign pins = {PRESET_VALUE_I,
                  PRESET_LOAD_N_I,
                  COUNT_INHIBIT_I,
                  COUNT_DOWN_I,
                  COUNT_CLOCK_I};

   always_comb begin
      sync1_next = pins;
      // Only the second stage ever reads the first
      sync2_next = sync1_reg;
   end

   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sync1_reg <= bcdc_pkg::SYNC_RST;
         sync2_reg <= bcdc_pkg::SYNC_RST;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
      end
   end

   assign clk_s = sync2_reg[bcdc_pkg::SB_CLK];
   assign dir_s = sync2_reg[bcdc_pkg::SB_DIR];
   assign inh_s = sync2_reg[bcdc_pkg::SB_INH];
   assign load_n_s = sync2_reg[bcdc_pkg::SB_LOAD];
   assign pre_s = sync2_reg[bcdc_pkg::SB_PRE +: bcdc_pkg::DIGIT_W];

   // ==========================================
   // Count clock edge detector
   // Reset level matches the synchroniser's clock bit,
   // so leaving reset never shows a false rise
   logic clk_prev_reg;
   logic clk_prev_next;
   logic clk_rise;

   always_comb begin
      clk_prev_next = clk_s;
   end

   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         clk_prev_reg <= bcdc_pkg::SYNC_RST[bcdc_pkg::SB_CLK];
      end else begin
         clk_prev_reg <= clk_prev_next;
      end
   end

   // Count clock must stay in each level one period to be seen
   assign clk_rise = clk_s & ~clk_prev_reg;

   // ==========================================
   // Mode decode
   typedef enum logic [1:0] {
      BCDC_HOLD = 2'b00,
      BCDC_UP = 2'b01,
      BCDC_DOWN = 2'b10,
      BCDC_LOAD = 2'b11
   } bcdc_mode_t;

   bcdc_mode_t mode;

   // Load wins over everything, then inhibit, then the clock edge
   always_comb begin
      if (!load_n_s) begin
         mode = BCDC_LOAD;
      end else if (inh_s || !clk_rise) begin
         mode = BCDC_HOLD;
      end else if (dir_s) begin
         mode = BCDC_DOWN;
      end else begin
         mode = BCDC_UP;
      end
   end

   // ==========================================
   // Digit arithmetic
   // Codes above nine, reachable only by preset, fall back to zero going up
   function automatic logic [3:0] digit_up(input logic [3:0] value);
      logic [3:0] result;
      if (value >= bcdc_pkg::DIGIT_MAX) begin
         result = bcdc_pkg::DIGIT_MIN;
      end else begin
         result = value + bcdc_pkg::DIGIT_ONE;
      end
      return result;
   endfunction : digit_up

   // Down from an illegal code simply decrements toward nine
   function automatic logic [3:0] digit_down(input logic [3:0] value);
      logic [3:0] result;
      if (value == bcdc_pkg::DIGIT_MIN) begin
         result = bcdc_pkg::DIGIT_MAX;
      end else begin
         result = value - bcdc_pkg::DIGIT_ONE;
      end
      return result;
   endfunction : digit_down

   // ==========================================
   // Counter state
   logic [3:0] count_reg;
   logic [3:0] count_next;

   always_comb begin
      unique case (mode)
         BCDC_LOAD: begin
            // Level-sensitive: preset follows the inputs while load is low
            count_next = pre_s;
         end
         BCDC_UP: begin
            count_next = digit_up(count_reg);
         end
         BCDC_DOWN: begin
            count_next = digit_down(count_reg);
         end
         BCDC_HOLD: begin
            count_next = count_reg;
         end
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         count_reg <= bcdc_pkg::COUNT_RST;
      end else begin
         count_reg <= count_next;
      end
   end

   // ==========================================
   // Terminal count
   // Taken from the next state so that it moves on the same edge as
   // the count; depends on state and direction only, never on inhibit
   logic tc_reg;
   logic tc_next;
   logic at_top;
   logic at_bottom;

   always_comb begin
      at_top = (count_next == bcdc_pkg::DIGIT_MAX);
      at_bottom = (count_next == bcdc_pkg::DIGIT_MIN);
      if (dir_s) begin
         tc_next = at_bottom;
      end else begin
         tc_next = at_top;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         tc_reg <= bcdc_pkg::TC_RST;
      end else begin
         tc_reg <= tc_next;
      end
   end

   // ==========================================
   // Ripple clock
   // Low only through the low half of the count clock; it uses the
   // registered terminal count, so a stage reads the state it shows
   // Limitation: an inhibit or load change inside the low half ends
   // the pulse early, exactly as the output gating demands
   logic ripple_reg;
   logic ripple_next;
   logic ripple_gate;

   always_comb begin
      ripple_gate = load_n_s & ~inh_s & tc_reg;
      if (ripple_gate && !clk_s) begin
         ripple_next = 1'b0;
      end else begin
         ripple_next = 1'b1;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ripple_reg <= bcdc_pkg::RIPPLE_RST;
      end else begin
         ripple_reg <= ripple_next;
      end
   end

   // ==========================================
   // Outputs
   // All three come straight from flip-flops, so a cascaded stage
   // never sees a decoding spike from this block
   assign COUNT_VALUE_O = count_reg;
   assign TERMINAL_COUNT_O = tc_reg;
   assign RIPPLE_CLOCK_OUT_O = ripple_reg;

endmodule : bcdc_counter

/* File: pkg/bcdc_pkg.sv */
package bcdc_pkg;
   // ==========================================
   // Widths and digit limits
   localparam int DIGIT_W = 4;
   localparam logic [3:0] DIGIT_MIN = 4'h0;
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   localparam logic [3:0] DIGIT_ONE = 4'h1;
   // ==========================================
   // Reset values
   localparam logic [3:0] COUNT_RST = 4'h0;
   localparam logic TC_RST = 1'b0;
   localparam logic RIPPLE_RST = 1'b1;
   // Input synchroniser reset levels: clock low, up, counting inhibited, load idle
   localparam logic [7:0] SYNC_RST = 8'h0c;
   // ==========================================
   // Synchroniser bit positions
   localparam int SB_CLK = 0;
   localparam int SB_DIR = 1;
   localparam int SB_INH = 2;
   localparam int SB_LOAD = 3;
   localparam int SB_PRE = 4;
   localparam int SYNC_W = 8;
endpackage : bcdc_pkg

/* File: tb/bcdc_properties.sv */
`timescale 1ns/100ps
module bcdc_properties (
   input wire logic CLOCK_I, RESETN_I, COUNT_CLOCK_I, PRESET_LOAD_N_I, COUNT_INHIBIT_I,
   input wire logic COUNT_DOWN_I, TERMINAL_COUNT_O, RIPPLE_CLOCK_OUT_O,
   input wire logic [3:0] PRESET_VALUE_I, COUNT_VALUE_O
);
   wire [3:0] q = COUNT_VALUE_O;
   wire [3:0] inc = (q == 4'h9) ? 4'h0 : q + 4'h1;
   wire [3:0] dec = (q == 4'h0) ? 4'h9 : q - 4'h1;
   wire ld = PRESET_LOAD_N_I, ih = COUNT_INHIBIT_I, dn = COUNT_DOWN_I;
   wire tc = TERMINAL_COUNT_O, rc = RIPPLE_CLOCK_OUT_O;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);
   sequence go; $rose(COUNT_CLOCK_I) && ld && !ih; endsequence
   a_load_copy: assert property (!$past(ld, 3) |-> q == $past(PRESET_VALUE_I, 3))
      else $error("load");
   a_hold_inh: assert property ($past(ih, 3) && $past(ld, 3) |-> $stable(q))
      else $error("hold");
   a_count_up: assert property (go ##0 !dn |-> ##3 q == $past(inc))
      else $error("up");
   a_count_dn: assert property (go ##0 dn |-> ##3 q == $past(dec))
      else $error("down");
   a_tc_level: assert property ($stable(dn) [*5] |-> tc == (dn ? q == 4'h0 : q == 4'h9))
      else $error("tc");
   a_rc_low: assert property ($fell(COUNT_CLOCK_I) && tc && ld && !ih |-> ##3 !rc)
      else $error("rc low");
   a_rc_high: assert property ($rose(COUNT_CLOCK_I) |-> ##3 rc)
      else $error("rc high");
   a_rc_inh: assert property (ih [*4] |-> ##3 rc)
      else $error("rc inhibit");
endmodule : bcdc_properties
bind bcdc_counter bcdc_properties i_bcdc_properties (.*);

/* File: tb/bcdc_clk_src.sv */
`timescale 1ns/100ps
module bcdc_clk_src (
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic RESETN_I,
   // Lower stage outputs and controls seen by the cascade
   input wire logic TERMINAL_COUNT_O,
   input wire logic RIPPLE_CLOCK_OUT_O,
   input wire logic COUNT_INHIBIT_I,
   input wire logic PRESET_LOAD_N_I,
   // Count clock and its phase
   output logic COUNT_CLOCK_I,
   output logic [3:0] ph_o,
   // Next decade, as built by two cascade styles
   output logic [3:0] tens_rip,
   output logic [3:0] tens_par
);
   logic rc_prev;
   // Eight-cycle halves leave setup margin around every rise
   assign COUNT_CLOCK_I = ph_o[3];
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ph_o <= 4'h0;
         rc_prev <= 1'b1;
         tens_rip <= 4'h0;
         tens_par <= 4'h0;
      end else begin
         ph_o <= ph_o + 4'h1;
         rc_prev <= RIPPLE_CLOCK_OUT_O;
         // Upper stage clocked by the lower ripple clock
         if (RIPPLE_CLOCK_OUT_O && !rc_prev) begin
            tens_rip <= (tens_rip == 4'h9) ? 4'h0 : tens_rip + 4'h1;
         end
         // Enable gated from lower terminal count, sampled at the count clock rise only
         if (ph_o == 4'h7 && TERMINAL_COUNT_O && !COUNT_INHIBIT_I && PRESET_LOAD_N_I) begin
            tens_par <= (tens_par == 4'h9) ? 4'h0 : tens_par + 4'h1;
         end
      end
   end
endmodule : bcdc_clk_src

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
   logic CLOCK_I = 1'b0, RESETN_I = 1'b0, PRESET_LOAD_N_I = 1'b1, COUNT_INHIBIT_I = 1'b1;
   logic COUNT_DOWN_I = 1'b0, COUNT_CLOCK_I, TERMINAL_COUNT_O, RIPPLE_CLOCK_OUT_O, t;
   logic l = 1'b1, i = 1'b1, d = 1'b0;
   logic [3:0] PRESET_VALUE_I = 4'h0, COUNT_VALUE_O, ph_o, tens_rip, tens_par;
   logic [31:0] r = 32'h602f1381;
   int err_total, cmp_count, st;
   always #20 CLOCK_I = ~CLOCK_I;
   bcdc_clk_src i_bcdc_clk_src (.*);
   bcdc_counter i_bcdc_counter (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [3:0] s, input logic [3:0] e);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("Error %0t: %h not %h", $time, s, e);
      end
   endtask : chk
   task automatic conclude();
      $display("compares %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   initial begin
      #(40 * 5000) err_total++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge CLOCK_I);
      RESETN_I <= 1'b1;
      repeat (4000) begin
         @(negedge CLOCK_I);
         // Controls change in the high half, well clear of the next rise and fall
         if (ph_o == 4'h9) begin
            r = lfsr(r);
            {l, i, d} = {r[3:2] != 2'h0, r[1:0] == 2'h0, r[4]};
            if (!l) st = r[11:8] % 10;
            @(posedge CLOCK_I);
            {PRESET_LOAD_N_I, COUNT_INHIBIT_I, COUNT_DOWN_I} <= {l, i, d};
            PRESET_VALUE_I <= 4'(r[11:8] % 10);
         end
         // Late in the low half all synchronised effects have landed
         if (ph_o == 4'h7) begin
            t = d ? st == 0 : st == 9;
            chk(COUNT_VALUE_O, 4'(st));
            chk(TERMINAL_COUNT_O, t);
            chk(RIPPLE_CLOCK_OUT_O, !(t && l && !i));
            chk(tens_rip, tens_par);
            if (l && !i) st = d ? (st + 9) % 10 : (st + 1) % 10;
         end
      end
      conclude();
   end
endmodule : tb
